// *** pkg/srp_pkg.sv ***
// Package of the host-side controller for the dual-mode serial register port.
// Shared by the controller, its quarter-bit tick generator and the bench.
package srp_pkg;

  // Clock rates used to derive the serial bit timing
  localparam int CLK_PERIOD_NS    = 50;   // System clock period
  localparam int SERCLK_PERIOD_NS = 400;  // Serial clock period made by the host
  // One serial bit is four quarters; a quarter is at least one system cycle
  localparam int QTR_CYC_CALC     = SERCLK_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_CYC          = (QTR_CYC_CALC < 1) ? 1 : QTR_CYC_CALC;

  // Fixed two-wire device address and direction bit values
  localparam logic [6:0] DEV_ADDR   = 7'h70;  // 1110000
  localparam logic       RW_WRITE   = 1'b0;
  localparam logic       RW_READ    = 1'b1;
  localparam logic [7:0] ADDR_WRITE = {DEV_ADDR, RW_WRITE};
  localparam logic [7:0] ADDR_READ  = {DEV_ADDR, RW_READ};

  // Write registers that take a single data byte
  localparam logic [7:0] SUB_ONE_A = 8'h03;
  localparam logic [7:0] SUB_ONE_B = 8'h08;
  localparam logic [7:0] SUB_ONE_C = 8'h0D;
  localparam logic [7:0] SUB_ONE_D = 8'h0E;

  // Last bit index of a byte slot on each protocol (two-wire adds the acknowledge slot)
  localparam logic [3:0] LAST_BIT_TWO   = 4'h8;
  localparam logic [3:0] LAST_BIT_THREE = 4'h7;
  localparam logic [3:0] ACK_BIT        = 4'h8;

  // Reset values of the pins and results
  localparam logic       SEL_RESET  = 1'b0;   // Two-wire after reset
  localparam logic [7:0] RD_RESET   = 8'h00;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_START = 5'b00010,
    ST_BIT   = 5'b00100,
    ST_STOP  = 5'b01000,
    ST_DONE  = 5'b10000
  } srp_state_t;

endpackage

// *** pkg/srp_tick_if.sv ***
// Interface between the controller and its quarter-bit tick generator.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface srp_tick_if;
  logic run;   // Sequencer busy, ticks wanted
  logic tick;  // One-cycle pulse at each quarter of a serial bit

  modport gen (input run, output tick);
  modport use_side (output run, input tick);
endinterface

// *** rtl/srp_tick_gen.sv ***
// Quarter-bit tick generator for the serial clock divider.
// Assumes clk is the system clock and reset is synchronous, active high.
`timescale 1ns/1ps
module srp_tick_gen
  import srp_pkg::*;
#(
  parameter int QUARTER = QTR_CYC  // System cycles per quarter bit
) (
  input  wire logic clk,      // System clock
  input  wire logic reset,    // Synchronous reset, active high
  srp_tick_if.gen   tickBus   // Run request in, tick out
);

  localparam int CW = (QUARTER < 2) ? 1 : $clog2(QUARTER);
  localparam logic [CW-1:0] CNT_LAST = CW'(QUARTER - 1);

  logic [CW-1:0] cnt_ff;   // Cycle count inside one quarter
  logic [CW-1:0] nxt_cnt;  // Next count

  // Restart the count when idle so the first quarter is always full length
  always_comb begin
    if (!tickBus.run || cnt_ff == CNT_LAST) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  // Register the count
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Tick on the last cycle of each quarter
  assign tickBus.tick = tickBus.run && (cnt_ff == CNT_LAST);

endmodule

// *** rtl/srp_host.sv ***
// Host controller that drives the dual-mode serial register port of the device.
// Assumes the device data pin is pulled high outside and that the bench resolves
// the data wire from dataOut/dataOe.
`timescale 1ns/1ps
module srp_host
  import srp_pkg::*;
#(
  parameter int QUARTER = QTR_CYC  // System cycles per quarter serial bit
) (
  input  wire logic       clk,            // System clock, 20 MHz
  input  wire logic       reset,          // Synchronous reset, active high
  input  wire logic       cmdValid,       // Command request
  output logic            cmdReady,       // Controller idle, command taken
  input  wire logic       cmdRead,        // 1 = read, 0 = write
  input  wire logic       cmdThreeWire,   // 1 = three-wire, 0 = two-wire
  input  wire logic [7:0] cmdSubaddr,     // Register subaddress
  input  wire logic [15:0] cmdWrData,     // Write data, low byte for 8-bit regs
  output logic            rspValid,       // One-cycle pulse at transfer end
  output logic [7:0]      rspData,        // Read data
  output logic            rspAckErr,      // Missing acknowledge in last transfer
  output logic            protocolSelect, // Protocol select pin
  output logic            enableN,        // Three-wire enable pin, active low
  output logic            serialClock,    // Serial clock pin
  input  wire logic       dataIn,         // Serial data pin, level seen
  output logic            dataOut,        // Serial data pin, driven level
  output logic            dataOe          // Serial data pin, drive enable
);

  srp_tick_if tickBus ();  // Quarter ticks from the divider

  srp_tick_gen #(.QUARTER(QUARTER)) u_tick (
    .clk     (clk),
    .reset   (reset),
    .tickBus (tickBus)
  );

  srp_state_t  state_ff,   nxt_state;    // Sequencer state
  logic [1:0]  qtr_ff,     nxt_qtr;      // Quarter within a bit
  logic [3:0]  bitCnt_ff,  nxt_bitCnt;   // Bit within a byte slot
  logic [1:0]  byteIdx_ff, nxt_byteIdx;  // Byte slot within the frame
  logic [1:0]  lastIdx_ff, nxt_lastIdx;  // Index of the final byte slot
  logic        read_ff,    nxt_read;     // Transfer is a read
  logic        three_ff,   nxt_three;    // Three-wire transfer
  logic        twoByte_ff, nxt_twoByte;  // Addressed register has 16 bits
  logic [7:0]  sub_ff,     nxt_sub;      // Latched subaddress
  logic [15:0] wd_ff,      nxt_wd;       // Latched write data
  logic        scl_ff,     nxt_scl;      // Serial clock pin
  logic        sdaOut_ff,  nxt_sdaOut;   // Data pin level
  logic        sdaOe_ff,   nxt_sdaOe;    // Data pin enable
  logic        enN_ff,     nxt_enN;      // Enable pin
  logic        sel_ff,     nxt_sel;      // Protocol select pin
  logic [7:0]  rd_ff,      nxt_rd;       // Read shift register
  logic        ackErr_ff,  nxt_ackErr;   // Acknowledge missing
  logic        sync1_ff;                 // Data pin synchroniser, stage one
  logic        sync2_ff;                 // Data pin synchroniser, stage two

  logic [7:0]  curByte;   // Byte in the current slot
  logic        isRdByte;  // Current slot is clocked in from the device
  logic [3:0]  lastBit;   // Last bit of a slot
  logic        curBit;    // Bit to send

  assign tickBus.run = (state_ff != ST_IDLE) && (state_ff != ST_DONE);

  // Pin synchroniser; only the second stage is looked at by the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= dataIn;
      sync2_ff <= sync1_ff;
    end
  end

  // Byte in each slot; two-wire opens with the address, three-wire does not
  always_comb begin
    curByte = 8'hFF;
    if (three_ff) begin
      if (byteIdx_ff == 2'd0) begin
        curByte = sub_ff;
      end else if (byteIdx_ff == 2'd1 && twoByte_ff) begin
        curByte = wd_ff[15:8];
      end else if (!read_ff) begin
        curByte = wd_ff[7:0];
      end
    end else begin
      if (byteIdx_ff == 2'd0) begin
        curByte = ADDR_WRITE;
      end else if (byteIdx_ff == 2'd1) begin
        curByte = sub_ff;
      end else if (byteIdx_ff == 2'd2 && read_ff) begin
        curByte = ADDR_READ;
      end else if (byteIdx_ff == 2'd2 && twoByte_ff) begin
        curByte = wd_ff[15:8];
      end else if (!read_ff) begin
        curByte = wd_ff[7:0];
      end
    end
  end

  assign isRdByte = read_ff && (byteIdx_ff == lastIdx_ff);
  assign lastBit  = three_ff ? LAST_BIT_THREE : LAST_BIT_TWO;
  assign curBit   = curByte[3'(4'd7 - bitCnt_ff)];

  // Sequencer: pin changes inside a frame fall on quarter ticks; idle levels and the select pin are set without a tick
  always_comb begin
    nxt_state   = state_ff;
    nxt_qtr     = qtr_ff;
    nxt_bitCnt  = bitCnt_ff;
    nxt_byteIdx = byteIdx_ff;
    nxt_lastIdx = lastIdx_ff;
    nxt_read    = read_ff;
    nxt_three   = three_ff;
    nxt_twoByte = twoByte_ff;
    nxt_sub     = sub_ff;
    nxt_wd      = wd_ff;
    nxt_scl     = scl_ff;
    nxt_sdaOut  = sdaOut_ff;
    nxt_sdaOe   = sdaOe_ff;
    nxt_enN     = enN_ff;
    nxt_sel     = sel_ff;
    nxt_rd      = rd_ff;
    nxt_ackErr  = ackErr_ff;
    if (tickBus.tick) begin
      nxt_qtr = qtr_ff + 2'd1;
    end
    case (state_ff)
      ST_IDLE: begin
        // Idle levels: two-wire clock high, three-wire clock low, enable high
        nxt_scl   = !three_ff;
        nxt_sdaOut = 1'b0;
        nxt_sdaOe = 1'b0;
        nxt_enN   = 1'b1;
        nxt_qtr   = 2'd0;
        if (cmdValid) begin
          nxt_read    = cmdRead;
          nxt_three   = cmdThreeWire;
          nxt_sel     = cmdThreeWire;
          nxt_sub     = cmdSubaddr;
          nxt_wd      = cmdWrData;
          nxt_twoByte = !cmdRead && !(cmdSubaddr == SUB_ONE_A || cmdSubaddr == SUB_ONE_B ||
                        cmdSubaddr == SUB_ONE_C || cmdSubaddr == SUB_ONE_D);
          nxt_lastIdx = 2'(cmdThreeWire ? (cmdRead ? 1 : (nxt_twoByte ? 2 : 1))
                                        : (cmdRead ? 3 : (nxt_twoByte ? 3 : 2)));
          nxt_byteIdx = 2'd0;
          nxt_bitCnt  = 4'd0;
          nxt_ackErr  = 1'b0;
          nxt_rd      = RD_RESET;
          nxt_state   = ST_START;
        end
      end
      ST_START: begin
        if (tickBus.tick) begin
          if (three_ff) begin
            // Enable falls with the clock low, then bits follow
            nxt_scl = 1'b0;
            nxt_enN = 1'b0;
            if (qtr_ff == 2'd3) begin
              nxt_state = ST_BIT;
            end
          end else begin
            // Data falls while the clock is high: begin or repeated begin
            case (qtr_ff)
              2'd0: begin
                nxt_scl   = 1'b0;
                nxt_sdaOe = 1'b0;
              end
              2'd1: nxt_scl = 1'b1;
              2'd2: nxt_sdaOe = 1'b1;
              default: begin
                nxt_scl   = 1'b0;
                nxt_state = ST_BIT;
              end
            endcase
          end
        end
      end
      ST_BIT: begin
        if (tickBus.tick) begin
          case (qtr_ff)
            2'd0: begin
              // Data moves only while the clock is low
              if (isRdByte || bitCnt_ff == ACK_BIT) begin
                nxt_sdaOut = 1'b0;
                nxt_sdaOe  = 1'b0;
              end else if (three_ff) begin
                nxt_sdaOut = curBit;
                nxt_sdaOe  = 1'b1;
              end else begin
                nxt_sdaOut = 1'b0;
                nxt_sdaOe  = !curBit;
              end
            end
            2'd1: nxt_scl = 1'b1;
            2'd2: begin
              // Sample in the middle of the clock-high phase
              if (isRdByte && bitCnt_ff != ACK_BIT) begin
                nxt_rd = {rd_ff[6:0], sync2_ff};
              end else if (!isRdByte && bitCnt_ff == ACK_BIT && sync2_ff) begin
                nxt_ackErr = 1'b1;
              end
            end
            default: begin
              nxt_scl    = 1'b0;
              nxt_bitCnt = bitCnt_ff + 4'd1;
              if (bitCnt_ff == lastBit) begin
                nxt_bitCnt = 4'd0;
                if (ackErr_ff || byteIdx_ff == lastIdx_ff) begin
                  nxt_state = ST_STOP;
                end else begin
                  nxt_byteIdx = byteIdx_ff + 2'd1;
                  if (!three_ff && read_ff && byteIdx_ff == 2'd1) begin
                    nxt_state = ST_START;
                  end
                end
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tickBus.tick) begin
          if (three_ff) begin
            nxt_scl   = 1'b0;
            nxt_sdaOe = 1'b0;
            if (qtr_ff == 2'd3) begin
              nxt_enN   = 1'b1;
              nxt_state = ST_DONE;
            end
          end else begin
            // Data rises while the clock is high: end condition
            case (qtr_ff)
              2'd0: begin
                nxt_scl    = 1'b0;
                nxt_sdaOut = 1'b0;
                nxt_sdaOe  = 1'b1;
              end
              2'd1: nxt_scl = 1'b1;
              2'd2: nxt_sdaOe = 1'b0;
              default: nxt_state = ST_DONE;
            endcase
          end
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Register the sequencer state and pins
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff   <= ST_IDLE;
      qtr_ff     <= 2'd0;
      bitCnt_ff  <= 4'd0;
      byteIdx_ff <= 2'd0;
      lastIdx_ff <= 2'd0;
      read_ff    <= 1'b0;
      three_ff   <= SEL_RESET;
      twoByte_ff <= 1'b0;
      sub_ff     <= 8'h00;
      wd_ff      <= 16'h0000;
      scl_ff     <= 1'b1;
      sdaOut_ff  <= 1'b0;
      sdaOe_ff   <= 1'b0;
      enN_ff     <= 1'b1;
      sel_ff     <= SEL_RESET;
      rd_ff      <= RD_RESET;
      ackErr_ff  <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      qtr_ff     <= nxt_qtr;
      bitCnt_ff  <= nxt_bitCnt;
      byteIdx_ff <= nxt_byteIdx;
      lastIdx_ff <= nxt_lastIdx;
      read_ff    <= nxt_read;
      three_ff   <= nxt_three;
      twoByte_ff <= nxt_twoByte;
      sub_ff     <= nxt_sub;
      wd_ff      <= nxt_wd;
      scl_ff     <= nxt_scl;
      sdaOut_ff  <= nxt_sdaOut;
      sdaOe_ff   <= nxt_sdaOe;
      enN_ff     <= nxt_enN;
      sel_ff     <= nxt_sel;
      rd_ff      <= nxt_rd;
      ackErr_ff  <= nxt_ackErr;
    end
  end

  // Port drive; the device side keeps its own open-drain output
  assign cmdReady       = (state_ff == ST_IDLE);
  assign rspValid       = (state_ff == ST_DONE);
  assign rspData        = rd_ff;
  assign rspAckErr      = ackErr_ff;
  assign protocolSelect = sel_ff;
  assign enableN        = enN_ff;
  assign serialClock    = scl_ff;
  assign dataOut        = sdaOut_ff;
  assign dataOe         = sdaOe_ff;

endmodule

// *** verif/srp_host_asserts.sv ***
// Checker for the serial port host: handshake and pin timing.
// Sees only host ports; bound into every srp_host instance.
`timescale 1ns/1ps
module srp_host_asserts (
  input wire logic       clk,            // System clock
  input wire logic       reset,          // Sync reset
  input wire logic       cmdValid,       // Request
  input wire logic       cmdReady,       // Idle
  input wire logic       cmdThreeWire,   // Mode asked
  input wire logic       rspValid,       // Done pulse
  input wire logic [7:0] rspData,        // Read byte
  input wire logic       protocolSelect, // Select pin
  input wire logic       enableN,        // Enable pin
  input wire logic       serialClock,    // Serial clock
  input wire logic       dataOut,        // Data level
  input wire logic       dataOe          // Data drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_sel_follow: assert property (
    cmdValid && cmdReady |=> protocolSelect == $past(cmdThreeWire))
    else $error("select pin does not follow command");
  // A frame must finish; long frames are about 320 cycles at quarter 2
  a_rsp_bound: assert property (
    cmdValid && cmdReady |-> ##[2:1000] rspValid)
    else $error("transfer never completed");
  a_idle_after: assert property (
    rspValid |=> !rspValid && cmdReady)
    else $error("done pulse not single or not back to idle");
  // Open drain in two-wire: the host only ever pulls low
  a_two_wire_oc: assert property (
    !protocolSelect |-> !dataOut)
    else $error("two-wire data driven high");
  a_three_hold: assert property (
    protocolSelect && !enableN && serialClock && $past(serialClock)
    && dataOe && $past(dataOe) |-> $stable(dataOut))
    else $error("three-wire data moved while clock high");
  a_clk_in_frame: assert property (
    protocolSelect && $rose(serialClock) |-> !enableN)
    else $error("serial clock pulsed with enable high");
  a_idle_pins: assert property (
    cmdReady |-> enableN && (protocolSelect ? !serialClock : serialClock && !dataOe))
    else $error("pins not idle between frames");
  a_rd_hold: assert property (
    cmdReady && !cmdValid |=> $stable(rspData))
    else $error("read byte changed while idle");
endmodule

bind srp_host srp_host_asserts u_chk (.clk, .reset, .cmdValid, .cmdReady, .cmdThreeWire,
  .rspValid, .rspData, .protocolSelect, .enableN, .serialClock, .dataOut, .dataOe);

// *** verif/srp_dev_model.sv ***
// Behavioural model of the device's serial register port.
// Runs on the port pin edges only, with no system clock; the bench resolves the pulled-up wire.
`timescale 1ns/1ps
module srp_dev_model #(
  parameter logic [7:0] STAT_VAL = 8'h5A, // Status byte, arbitrary
  parameter logic [7:0] ADC_VAL  = 8'hC3  // Converter byte, arbitrary
) (
  input  wire logic protocolSelect, // 0 two-wire, 1 three-wire
  input  wire logic enableN,        // Frame enable, active low
  input  wire logic serialClock,    // Serial clock
  input  wire logic dataWire,       // Resolved data level
  input  wire logic nackAll,        // Refuse the address
  output logic      devPullLow      // Open-drain pull
);
  logic [15:0] regs [16];               // Write registers
  logic [7:0]  sh, sub, rdByte;         // Shifter, subaddress, read byte
  logic [15:0] dat;                     // Data bytes so far
  int          bitCnt, byteIdx, nb;     // Slot counters
  logic        active, ackOk, reading, readPend;
  initial begin
    devPullLow = 1'b0;
    active = 1'b0;
    for (int i = 0; i < 16; i++) regs[i] = 16'h0000;
  end
  // Byte decode: address, subaddress, then data MSB first
  task automatic gotByte();
    ackOk = 1'b1;
    if (byteIdx == 0 && !protocolSelect) begin
      ackOk = sh[7:1] == 7'h70 && !nackAll;
      readPend = sh[0];
      active = ackOk;
    end else if (byteIdx == (protocolSelect ? 0 : 1)) begin
      sub = sh;
      nb = 0;
      reading = protocolSelect && sub[7];
    end else begin
      dat = {dat[7:0], sh};
      nb++;
    end
    rdByte = (sub == 8'h80) ? STAT_VAL : (sub == 8'h81) ? ADC_VAL : 8'hFF;
    byteIdx++;
  endtask
  // Latch only a complete write to a valid subaddress
  task automatic commit();
    if (active && sub <= 8'h0F && nb == ((sub inside {3, 8, 13, 14}) ? 1 : 2))
      regs[sub[3:0]] = (nb == 1) ? {8'h00, dat[7:0]} : dat;
    active = 1'b0;
    devPullLow = 1'b0;
  endtask
  // Begin and end conditions: data edge while clock high
  always @(negedge dataWire) if (serialClock && !protocolSelect) begin
    active = 1'b1;
    {bitCnt, byteIdx, reading, readPend} = '0;
  end
  always @(posedge dataWire) if (serialClock && !protocolSelect) commit();
  // Three-wire frames live only while enable is low
  always @(negedge enableN) if (protocolSelect) begin
    active = 1'b1;
    {bitCnt, byteIdx, reading} = '0;
  end
  always @(posedge enableN) if (protocolSelect) commit();
  // Sample on the rising clock, no internal clock used
  always @(posedge serialClock) if (active && (!protocolSelect || !enableN)) begin
    if (bitCnt < 8) begin
      if (!reading) sh = {sh[6:0], dataWire};
      bitCnt++;
      if (bitCnt == 8 && !reading) gotByte();
      if (bitCnt == 8 && protocolSelect) bitCnt = 0;
    end else bitCnt = 9;
  end
  // Drive on the falling clock: acknowledge slot, then read bits
  always @(negedge serialClock) if (active) begin
    if (!protocolSelect && bitCnt == 8) devPullLow = !reading && ackOk;
    else if (!protocolSelect && bitCnt == 9) begin
      bitCnt = 0;
      reading = readPend;
      // One read byte only: the host does not acknowledge it, so let go after
      readPend = 1'b0;
      devPullLow = reading && !rdByte[7];
    end else devPullLow = reading && bitCnt < 8 && !rdByte[7-bitCnt];
  end
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for srp_host against the device model.
// Expected registers are kept here from the commands that were sent.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
  import srp_pkg::*;
  logic        clk, reset, cmdValid, cmdRead, cmdThreeWire, nackAll;
  logic [7:0]  cmdSubaddr, rspData;
  logic [15:0] cmdWrData;
  logic        cmdReady, rspValid, rspAckErr, protocolSelect, enableN;
  logic        serialClock, dataOut, dataOe, devPullLow, dataWire;
  logic [15:0] expReg [16];              // Expected register file
  int          err_count, tests_run;
  logic [14:0] idlePins;                 // Port levels checked after each reset
  // Idle levels: ready, no response, two-wire select, enable high, clock high
  localparam logic [14:0] IDLE_EXP = {3'b100, SEL_RESET, 3'b110, RD_RESET};
  assign idlePins = {cmdReady, rspValid, rspAckErr, protocolSelect, enableN, serialClock,
                     dataOe, rspData};
  // Pull-up wire: low when either party pulls it
  assign dataWire = ((dataOe && !dataOut) || devPullLow) ? 1'b0 : 1'b1;
  srp_host #(.QUARTER(2)) dut (.clk(clk), .reset(reset), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdThreeWire(cmdThreeWire),
    .cmdSubaddr(cmdSubaddr), .cmdWrData(cmdWrData), .rspValid(rspValid),
    .rspData(rspData), .rspAckErr(rspAckErr), .protocolSelect(protocolSelect),
    .enableN(enableN), .serialClock(serialClock), .dataIn(dataWire),
    .dataOut(dataOut), .dataOe(dataOe));
  srp_dev_model dev (.protocolSelect(protocolSelect), .enableN(enableN),
    .serialClock(serialClock), .dataWire(dataWire), .nackAll(nackAll),
    .devPullLow(devPullLow));
  always #25 clk = ~clk;
  // One command: hand over, wait bounded, compare every result
  task automatic runCmd(input logic three, input logic rd, input logic [7:0] sub,
                        input logic [15:0] wd);
    logic [7:0] expRd;
    logic       expErr;
    int         n;
    expRd = (sub == 8'h80) ? 8'h5A : (sub == 8'h81) ? 8'hC3 : 8'hFF;
    expErr = nackAll && !three;
    if (!rd && sub <= 8'h0F && !expErr)
      expReg[sub[3:0]] = (sub inside {3, 8, 13, 14}) ? {8'h00, wd[7:0]} : wd;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdRead <= rd;
    cmdThreeWire <= three;
    cmdSubaddr <= sub;
    cmdWrData <= wd;
    @(negedge clk);
    while (cmdReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmdValid <= 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    `CHK(rspValid, 1'b1)
    `CHK(rspAckErr, expErr)
    if (rd) `CHK(rspData, expRd)
    for (int i = 0; i < 16; i++) `CHK(dev.regs[i], expReg[i])
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog: about 187 frames of some 320 cycles each
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_sim();
  end
  initial begin
    {clk, cmdValid, cmdRead, cmdThreeWire, nackAll} = '0;
    {cmdSubaddr, cmdWrData, err_count, tests_run} = '0;
    reset = 1'b1;
    for (int i = 0; i < 16; i++) expReg[i] = 16'h0000;
    void'($urandom(32'h6376));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK(idlePins, IDLE_EXP)
    // Whole write map in each mode, back to back
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 16; s++) runCmd(m[0], 1'b0, s[7:0], 16'($urandom()));
      $display("write map mode %0d done", m);
    end
    // Both read registers plus one unmapped, then bad writes
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 3; s++) runCmd(m[0], 1'b1, 8'h80 + s[7:0], 16'h0000);
      runCmd(m[0], 1'b0, 8'h10, 16'hA55A);
      runCmd(m[0], 1'b0, 8'h7F, 16'h1234);
    end
    $display("read and refused subaddress tests done");
    // Device refuses its address: two-wire write flagged and not latched, three-wire write still latched
    nackAll = 1'b1;
    runCmd(1'b0, 1'b0, 8'h00, 16'hFFFF);
    runCmd(1'b1, 1'b0, 8'h0E, 16'h00C6);
    nackAll = 1'b0;
    $display("refused address test done");
    // Reset in the middle of a three-wire write: pins idle, nothing latched
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdRead <= 1'b0;
    cmdThreeWire <= 1'b1;
    cmdSubaddr <= 8'h01;
    cmdWrData <= 16'hBEEF;
    @(posedge clk);
    cmdValid <= 1'b0;
    repeat (40) @(posedge clk);
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    `CHK(idlePins, IDLE_EXP)
    `CHK(dev.regs[1], expReg[1])
    $display("mid-frame reset test done");
    // Random mix of modes, directions and subaddresses
    for (int k = 0; k < 16; k++) begin
      if ($urandom() % 2) runCmd(1'($urandom()), 1'b1, 8'h80 + 8'($urandom() % 3), 16'h0);
      else runCmd(1'($urandom()), 1'b0, 8'($urandom() % 18), 16'($urandom()));
    end
    $display("random mix done");
    end_sim();
  end
endmodule
